// ---- common/mrb_pkg.sv ----
// package: constants, encodings and field layout of the mode register bank
// assumes: single clock domain, 20 MHz, commands decoded upstream into strobes
// Function
// RULE1: each register is read-only, write-only, or read-write; controller respects class
// RULE2: registers reached only through mode register read and write commands
// RULE3: controller writes zeros in reserved operand bits
// RULE4: reserved operand bits read back as zero
// RULE5: read of reserved or write-only register gives undefined data, strobe still toggles
// RULE6: controller never writes a reserved register address
// RULE7: write to a read-only register is discarded without effect
// RULE8: status bit 0 reads 1 while auto-init runs, 0 when complete
// RULE9: status bit 1 and bit 2 read zero
// RULE10: status bits 4:3 report impedance pin self-test result
// RULE11: self-test field updated when initial impedance calibration completes
// RULE12: pin tied to command/address supply makes self-test field read 01
// RULE13: fault 01 or 10 forces factory impedance and ignores later calibrations
// RULE14: burst length codes 010, 011, 100 give 4, 8, 16 beats
// RULE15: burst order bit 3: 0 sequential, 1 interleaved
// RULE16: wrap bit 4: 0 wrap, 1 no wrap, only with 4-beat bursts
// RULE17: write recovery codes 001 to 110 give 3 to 8 cycles, default 3
// RULE18: auto-precharge write waits programmed recovery count before internal precharge
// RULE19: addresses 20H and 28H return calibration patterns A and B
// RULE20: controller avoids vendor ranges and do-not-use addresses
// RULE21: auto-init completes within 10 us after a reset command
// RULE22: write-only fields hold last write, reset to defaults, never readable
// RULE23: each command carries an 8-bit address and, for writes, 8-bit operand
package mrb_pkg;
  localparam logic [7:0] ADDR_DEV_INFO   = 8'h00;
  localparam logic [7:0] ADDR_BURST_WR   = 8'h01;
  localparam logic [7:0] ADDR_LATENCY    = 8'h02;
  localparam logic [7:0] ADDR_DRIVE      = 8'h03;
  localparam logic [7:0] ADDR_REFRESH    = 8'h04;
  localparam logic [7:0] ADDR_MAKER      = 8'h05;
  localparam logic [7:0] ADDR_REV_ONE    = 8'h06;
  localparam logic [7:0] ADDR_REV_TWO    = 8'h07;
  localparam logic [7:0] ADDR_WIDTH_DENS = 8'h08;
  localparam logic [7:0] ADDR_TEST_CTL   = 8'h09;
  localparam logic [7:0] ADDR_CAL_CMD    = 8'h0A;
  localparam logic [7:0] ADDR_PARTIAL_ARRAY_REFRESH_MASK  = 8'h10;
  localparam logic [7:0] ADDR_PATTERN_A  = 8'h20;
  localparam logic [7:0] ADDR_PATTERN_B  = 8'h28;
  localparam logic [7:0] ADDR_RESET_CMD  = 8'h3F;

  localparam int BIT_AUTO_INIT  = 0;
  localparam int BIT_DEV_TYPE   = 1;
  localparam int BIT_INV_DATA   = 2;
  localparam int POS_SELFTEST   = 3;
  localparam int POS_BURST_LEN  = 0;
  localparam int POS_BURST_ORD  = 3;
  localparam int POS_BURST_WRAP = 4;
  localparam int POS_WR_CYCLES  = 5;

  localparam logic [2:0] BL_4  = 3'h2;
  localparam logic [2:0] BL_8  = 3'h3;
  localparam logic [2:0] BL_16 = 3'h4;
  localparam logic [2:0] WR_MIN_CODE = 3'h1;
  localparam logic [2:0] WR_MAX_CODE = 3'h6;
  localparam logic [3:0] WR_CODE_OFFSET = 4'h2;

  localparam logic [7:0] RST_BURST_WR = 8'h22;
  localparam logic [7:0] RST_LATENCY  = 8'h01;
  localparam logic [7:0] RST_DRIVE    = 8'h02;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] MASK_DEV_INFO = 8'h1F;

  localparam logic [1:0] ST_NOT_RUN   = 2'h0;
  localparam logic [1:0] ST_PIN_HIGH  = 2'h1;
  localparam logic [1:0] ST_PIN_SHORT = 2'h2;
  localparam logic [1:0] ST_PIN_GOOD  = 2'h3;

  localparam logic [7:0] CAL_INIT_CODE = 8'hFF;

  localparam int CLK_HZ          = 20_000_000;
  localparam int AUTO_INIT_US    = 10;
  localparam int AUTO_INIT_CYC   = (AUTO_INIT_US * CLK_HZ) / 1_000_000;
  localparam int CAL_INIT_NS     = 1000;
  localparam int CAL_INIT_CYC    = (CAL_INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {MRB_IDLE, MRB_AUTO_INIT, MRB_CAL} mrb_phase_e;
endpackage

// ---- hw/mrb_bank.sv ----
// mode register bank: decodes register read/write strobes, holds config and status
// assumes: command decoder supplies one-cycle strobes with 8-bit address and operand
module mrb_bank #(
  parameter int AUTO_INIT_CYCLES = mrb_pkg::AUTO_INIT_CYC,
  parameter int CAL_CYCLES       = mrb_pkg::CAL_INIT_CYC,
  parameter logic [7:0] MAKER_ID   = 8'h5A, // arbitrary value
  parameter logic [7:0] REV_ONE_ID = 8'h01, // arbitrary value
  parameter logic [7:0] REV_TWO_ID = 8'h00, // arbitrary value
  parameter logic [7:0] WIDTH_DENS = 8'h14,
  parameter logic [7:0] PATTERN_A  = 8'h55,
  parameter logic [7:0] PATTERN_B  = 8'h3C
) (
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  input  wire logic       MRR_STB,
  input  wire logic       MRW_STB,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_OPERAND,
  input  wire logic [1:0] PIN_SELFTEST_RESULT,
  input  wire logic [2:0] REFRESH_RATE,
  input  wire logic       TEMP_UPDATE_FLAG,
  input  wire logic       WRITE_AP_DONE,
  output logic [7:0]      READ_DATA,
  output logic            READ_VALID,
  output logic            DATA_STROBE_TOGGLE,
  output logic            AUTO_INIT_BUSY,
  output logic [2:0]      BURST_LENGTH,
  output logic            BURST_ORDER,
  output logic            BURST_WRAP_SELECT,
  output logic [3:0]      WRITE_RECOVERY_CYCLES,
  output logic [7:0]      LATENCY_CODE,
  output logic [3:0]      DRIVE_CODE,
  output logic            FACTORY_IMPEDANCE,
  output logic            INTERNAL_PRECHARGE,
  output logic [7:0]      PARTIAL_ARRAY_REFRESH_MASK,
  output logic [7:0]      TEST_CONTROL
);

  typedef struct packed {
    mrb_pkg::mrb_phase_e phase;
    logic [15:0] timer;
    logic [1:0]  selftest;
    logic        factory;
    logic [7:0]  burst_wr;
    logic [7:0]  latency;
    logic [7:0]  drive;
    logic [7:0]  partial_array_refresh;
    logic [7:0]  test;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        dqs;
    logic        wr_pending;
    logic [3:0]  wr_count;
    logic        precharge;
    logic        busy;
    logic [3:0]  wr_cyc;
  } mrb_state_s;

  mrb_state_s st_reg;
  mrb_state_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [7:0] rd_mux;
  logic [3:0] wr_cycles;

  assign wr_cycles = st_reg.wr_cyc; // RULE17

  always_comb begin
    case (REG_ADDR)
      mrb_pkg::ADDR_DEV_INFO: begin
        // type and invalid-data bits tied low, upper bits forced zero
        rd_mux = {3'h0, st_reg.selftest, 1'b0, 1'b0,
                  st_reg.phase == mrb_pkg::MRB_AUTO_INIT}; // RULE4 RULE8 RULE9 RULE10
      end
      mrb_pkg::ADDR_REFRESH:    rd_mux = {TEMP_UPDATE_FLAG, 4'h0, REFRESH_RATE}; // RULE4
      mrb_pkg::ADDR_MAKER:      rd_mux = MAKER_ID;
      mrb_pkg::ADDR_REV_ONE:    rd_mux = REV_ONE_ID;
      mrb_pkg::ADDR_REV_TWO:    rd_mux = REV_TWO_ID;
      mrb_pkg::ADDR_WIDTH_DENS: rd_mux = WIDTH_DENS;
      mrb_pkg::ADDR_PATTERN_A:  rd_mux = PATTERN_A; // RULE19
      mrb_pkg::ADDR_PATTERN_B:  rd_mux = PATTERN_B; // RULE19
      // write-only and reserved: undefined data, chosen as zero
      default:                  rd_mux = 8'h00; // RULE5 RULE22
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic is_ro_addr;
  assign is_ro_addr = (REG_ADDR == mrb_pkg::ADDR_DEV_INFO) ||
                      (REG_ADDR == mrb_pkg::ADDR_REFRESH)  ||
                      (REG_ADDR == mrb_pkg::ADDR_MAKER)    ||
                      (REG_ADDR == mrb_pkg::ADDR_REV_ONE)  ||
                      (REG_ADDR == mrb_pkg::ADDR_REV_TWO)  ||
                      (REG_ADDR == mrb_pkg::ADDR_WIDTH_DENS) ||
                      (REG_ADDR == mrb_pkg::ADDR_PATTERN_A) ||
                      (REG_ADDR == mrb_pkg::ADDR_PATTERN_B);

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.precharge = 1'b0;

    // every read answers and toggles the strobe, whatever the class
    if (MRR_STB) begin
      st_next.rdata  = rd_mux; // RULE1 RULE23
      st_next.rvalid = 1'b1;
      st_next.dqs    = ~st_reg.dqs; // RULE5
    end

    case (st_reg.phase)
      mrb_pkg::MRB_AUTO_INIT: begin
        if (st_reg.timer == 16'h0000) begin
          st_next.phase = mrb_pkg::MRB_IDLE; // RULE21
        end else begin
          st_next.timer = st_reg.timer - 16'h0001;
        end
      end
      mrb_pkg::MRB_CAL: begin
        if (st_reg.timer == 16'h0000) begin
          st_next.phase    = mrb_pkg::MRB_IDLE;
          st_next.selftest = PIN_SELFTEST_RESULT; // RULE11 RULE12
          st_next.factory  = (PIN_SELFTEST_RESULT == mrb_pkg::ST_PIN_HIGH) ||
                             (PIN_SELFTEST_RESULT == mrb_pkg::ST_PIN_SHORT); // RULE13
        end else begin
          st_next.timer = st_reg.timer - 16'h0001;
        end
      end
      default: st_next.phase = mrb_pkg::MRB_IDLE;
    endcase

    // read-only targets are blocked by is_ro_addr before the decode
    if (MRW_STB && !is_ro_addr) begin // RULE7
      case (REG_ADDR)
        mrb_pkg::ADDR_BURST_WR:  st_next.burst_wr = REG_OPERAND; // RULE14 RULE15 RULE16
        mrb_pkg::ADDR_LATENCY:   st_next.latency  = REG_OPERAND;
        mrb_pkg::ADDR_DRIVE:     st_next.drive    = REG_OPERAND;
        mrb_pkg::ADDR_TEST_CTL:  st_next.test     = REG_OPERAND;
        mrb_pkg::ADDR_PARTIAL_ARRAY_REFRESH_MASK: st_next.partial_array_refresh     = REG_OPERAND;
        mrb_pkg::ADDR_CAL_CMD: begin
          // faulted pin: calibration commands dropped until a reset command clears factory
          if (!st_reg.factory && REG_OPERAND == mrb_pkg::CAL_INIT_CODE &&
              st_reg.phase == mrb_pkg::MRB_IDLE) begin // RULE13
            st_next.phase = mrb_pkg::MRB_CAL;
            st_next.timer = 16'(CAL_CYCLES - 1);
          end
        end
        mrb_pkg::ADDR_RESET_CMD: begin
          st_next.phase    = mrb_pkg::MRB_AUTO_INIT; // RULE21 RULE22
          st_next.timer    = 16'(AUTO_INIT_CYCLES - 1);
          st_next.burst_wr = mrb_pkg::RST_BURST_WR;
          st_next.latency  = mrb_pkg::RST_LATENCY;
          st_next.drive    = mrb_pkg::RST_DRIVE;
          st_next.partial_array_refresh     = mrb_pkg::RST_ZERO;
          st_next.test     = mrb_pkg::RST_ZERO;
          st_next.selftest = mrb_pkg::ST_NOT_RUN;
          st_next.factory  = 1'b0;
        end
        default: ; // reserved addresses: controller must not write them
      endcase
    end

    // auto-precharge write: count the programmed recovery cycles
    if (st_reg.wr_pending) begin
      if (st_reg.wr_count <= 4'h1) begin
        st_next.wr_pending = 1'b0;
        st_next.precharge  = 1'b1; // RULE18
      end else begin
        st_next.wr_count = st_reg.wr_count - 4'h1;
      end
    end else if (WRITE_AP_DONE) begin
      // load takes a cycle itself, so start one short to land on cycle N
      st_next.wr_pending = 1'b1;
      st_next.wr_count   = wr_cycles - 4'h1; // RULE18
    end

    // registered copies so these outputs leave straight from flops
    st_next.busy   = st_next.phase == mrb_pkg::MRB_AUTO_INIT;
    st_next.wr_cyc = {1'b0, st_next.burst_wr[7:5]} + mrb_pkg::WR_CODE_OFFSET; // RULE17
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= '{phase: mrb_pkg::MRB_AUTO_INIT,
                  timer: 16'(AUTO_INIT_CYCLES - 1),
                  selftest: mrb_pkg::ST_NOT_RUN,
                  factory: 1'b0,
                  burst_wr: mrb_pkg::RST_BURST_WR,
                  latency: mrb_pkg::RST_LATENCY,
                  drive: mrb_pkg::RST_DRIVE,
                  partial_array_refresh: mrb_pkg::RST_ZERO,
                  test: mrb_pkg::RST_ZERO,
                  rdata: 8'h00,
                  rvalid: 1'b0,
                  dqs: 1'b0,
                  wr_pending: 1'b0,
                  wr_count: 4'h0,
                  precharge: 1'b0,
                  busy: 1'b1,
                  wr_cyc: {1'b0, mrb_pkg::RST_BURST_WR[7:5]} + mrb_pkg::WR_CODE_OFFSET};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all flops

  assign READ_DATA             = st_reg.rdata;
  assign READ_VALID            = st_reg.rvalid;
  assign DATA_STROBE_TOGGLE    = st_reg.dqs;
  assign AUTO_INIT_BUSY        = st_reg.busy;
  assign BURST_LENGTH          = st_reg.burst_wr[2:0];
  assign BURST_ORDER           = st_reg.burst_wr[3];
  assign BURST_WRAP_SELECT     = st_reg.burst_wr[4];
  assign WRITE_RECOVERY_CYCLES = wr_cycles;
  assign LATENCY_CODE          = st_reg.latency;
  assign DRIVE_CODE            = st_reg.drive[3:0];
  assign FACTORY_IMPEDANCE     = st_reg.factory;
  assign INTERNAL_PRECHARGE    = st_reg.precharge;
  assign PARTIAL_ARRAY_REFRESH_MASK             = st_reg.partial_array_refresh;
  assign TEST_CONTROL          = st_reg.test;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_ro_write_ignored: assert property (@(posedge CLK) disable iff (!ARST_N)
    MRW_STB && REG_ADDR == mrb_pkg::ADDR_DEV_INFO && !MRR_STB &&
    st_reg.phase == mrb_pkg::MRB_IDLE && !WRITE_AP_DONE && !st_reg.wr_pending
    |=> $stable(st_reg.burst_wr) && $stable(st_reg.selftest)) // RULE7
    else $error("write to read-only register changed state");

  chk_read_strobe_toggle: assert property (@(posedge CLK) disable iff (!ARST_N)
    MRR_STB |=> READ_VALID && DATA_STROBE_TOGGLE != $past(DATA_STROBE_TOGGLE)) // RULE5
    else $error("read did not toggle strobe");

  chk_devinfo_zero_bits: assert property (@(posedge CLK) disable iff (!ARST_N)
    MRR_STB && REG_ADDR == mrb_pkg::ADDR_DEV_INFO
    |=> (READ_DATA & ~mrb_pkg::MASK_DEV_INFO) == 8'h00 && READ_DATA[2:1] == 2'h0) // RULE4
    else $error("reserved or fixed device-info bits not zero");

  chk_auto_init_bit: assert property (@(posedge CLK) disable iff (!ARST_N)
    MRR_STB && REG_ADDR == mrb_pkg::ADDR_DEV_INFO
    |=> READ_DATA[0] == $past(AUTO_INIT_BUSY)) // RULE8
    else $error("auto-init bit mismatch");

  chk_reset_cmd_init: assert property (@(posedge CLK) disable iff (!ARST_N)
    MRW_STB && REG_ADDR == mrb_pkg::ADDR_RESET_CMD
    |=> AUTO_INIT_BUSY && BURST_LENGTH == mrb_pkg::BL_4 &&
        WRITE_RECOVERY_CYCLES == 4'h3) // RULE21
    else $error("reset command did not restart auto-init with defaults");

  chk_auto_init_bound: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(AUTO_INIT_BUSY) |-> ##[1:200] !AUTO_INIT_BUSY) // RULE21
    else $error("auto-init exceeded its bound");

  chk_fault_ignores_cal: assert property (@(posedge CLK) disable iff (!ARST_N)
    FACTORY_IMPEDANCE && MRW_STB && REG_ADDR == mrb_pkg::ADDR_CAL_CMD
    |=> st_reg.phase != mrb_pkg::MRB_CAL) // RULE13
    else $error("calibration accepted after pin fault");

  chk_selftest_update: assert property (@(posedge CLK) disable iff (!ARST_N)
    st_reg.phase == mrb_pkg::MRB_CAL && st_reg.timer == 16'h0000 &&
    !(MRW_STB && REG_ADDR == mrb_pkg::ADDR_RESET_CMD)
    |=> st_reg.selftest == $past(PIN_SELFTEST_RESULT)) // RULE11
    else $error("self-test field not updated at calibration end");

  chk_burst_fields: assert property (@(posedge CLK) disable iff (!ARST_N)
    MRW_STB && REG_ADDR == mrb_pkg::ADDR_BURST_WR
    |=> BURST_LENGTH == $past(REG_OPERAND[2:0]) &&
        BURST_WRAP_SELECT == $past(REG_OPERAND[4])) // RULE14 RULE16
    else $error("burst config not written");

  chk_precharge_delay: assert property (@(posedge CLK) disable iff (!ARST_N)
    WRITE_AP_DONE && !st_reg.wr_pending && wr_cycles == 4'h3
    |=> !INTERNAL_PRECHARGE ##1 !INTERNAL_PRECHARGE ##1 INTERNAL_PRECHARGE) // RULE18
    else $error("precharge not after programmed recovery");

  cov_reset_cmd: cover property (@(posedge CLK) disable iff (!ARST_N)
    MRW_STB && REG_ADDR == mrb_pkg::ADDR_RESET_CMD);
  cov_cal_fault: cover property (@(posedge CLK) disable iff (!ARST_N)
    $rose(FACTORY_IMPEDANCE));
  cov_pattern_read: cover property (@(posedge CLK) disable iff (!ARST_N)
    MRR_STB && REG_ADDR == mrb_pkg::ADDR_PATTERN_B);
  cov_precharge: cover property (@(posedge CLK) disable iff (!ARST_N)
    INTERNAL_PRECHARGE);

endmodule

// ---- testbench/mrb_ctrl.sv ----
// controller-side model: issues mode register read and write commands
// assumes: bench clock, commands launched on the falling edge, one at a time
module mrb_ctrl (
  input  wire logic       clk,
  input  wire logic [7:0] read_data,
  input  wire logic       read_valid,
  output logic            mrr_stb,
  output logic            mrw_stb,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_operand
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mrr_stb = 1'b0;
    mrw_stb = 1'b0;
    reg_addr = 8'hA5;
    reg_operand = 8'h5A;
  end
  //////////////////////////////////////////////////////////////////////////////
  // callers never name vendor, do-not-use or reserved write addresses
  task automatic wr(input logic [7:0] a, input logic [7:0] op);
    @(negedge clk);
    mrw_stb = 1'b1;
    reg_addr = a;
    reg_operand = op;
    @(negedge clk);
    mrw_stb = 1'b0;
    // released lines must not look like the last command
    reg_addr = ~a;
    reg_operand = ~op;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    mrr_stb = 1'b1;
    reg_addr = a;
    @(negedge clk);
    mrr_stb = 1'b0;
    reg_addr = ~a;
    d = read_data;
    v = read_valid;
  endtask
endmodule

// ---- testbench/mrb_bank_tb.sv ----
// bench for the mode register bank: random and corner traffic, self-checking
// assumes: controller model drives the command strobes, bench drives the rest
module mrb_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         AI    = 5;
  localparam int         CC    = 3;
  localparam logic [7:0] PAT_A = 8'h55;
  localparam logic [7:0] PAT_B = 8'h3C;
  localparam logic [7:0] MAKER = 8'hC3; // arbitrary value
  logic       clk, arst_n, rr_stb, rw_stb, ap_done, temp_flag, rvalid, tgl, busy;
  logic       bord, bwrap, fact, pre;
  logic [1:0] selftest;
  logic [2:0] refresh, blen;
  logic [3:0] wrc, drv;
  logic [7:0] addr, oper, rdata, lat, partial_array_refresh, tctl, d, op;
  logic       v;
  int         n_fail, n_compared, cyc;
  logic [7:0] wo_list [8] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h10, 8'h3F, 8'h0B};

  mrb_bank #(.AUTO_INIT_CYCLES(AI), .CAL_CYCLES(CC), .MAKER_ID(MAKER),
             .PATTERN_A(PAT_A), .PATTERN_B(PAT_B)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .MRR_STB(rr_stb), .MRW_STB(rw_stb), .REG_ADDR(addr),
    .REG_OPERAND(oper), .PIN_SELFTEST_RESULT(selftest), .REFRESH_RATE(refresh),
    .TEMP_UPDATE_FLAG(temp_flag), .WRITE_AP_DONE(ap_done), .READ_DATA(rdata),
    .READ_VALID(rvalid), .DATA_STROBE_TOGGLE(tgl), .AUTO_INIT_BUSY(busy),
    .BURST_LENGTH(blen), .BURST_ORDER(bord), .BURST_WRAP_SELECT(bwrap),
    .WRITE_RECOVERY_CYCLES(wrc), .LATENCY_CODE(lat), .DRIVE_CODE(drv),
    .FACTORY_IMPEDANCE(fact), .INTERNAL_PRECHARGE(pre), .PARTIAL_ARRAY_REFRESH_MASK(partial_array_refresh),
    .TEST_CONTROL(tctl));
  mrb_ctrl u_ctl (.clk(clk), .read_data(rdata), .read_valid(rvalid), .mrr_stb(rr_stb),
                  .mrw_stb(rw_stb), .reg_addr(addr), .reg_operand(oper));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] info(input logic b, input logic [1:0] st);
    return {3'h0, st, 2'h0, b};
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic t0;
    t0 = tgl;
    u_ctl.rd(a, d, v);
    cmp("read_data", e, d);
    cmp("read_valid", 8'h01, 8'(v));
    cmp("strobe_toggle", {7'h00, ~t0}, 8'(tgl));
  endtask
  task automatic defaults_idle();
    cmp("busy", 8'h01, 8'(busy));
    cmp("burst_length", 8'h02, 8'(blen));
    cmp("burst_order", 8'h00, 8'(bord));
    cmp("burst_wrap", 8'h00, 8'(bwrap));
    cmp("recovery", 8'h03, 8'(wrc));
    cmp("latency", 8'h01, lat);
    cmp("drive", 8'h02, 8'(drv));
    cmp("partial_array_refresh", 8'h00, partial_array_refresh);
    for (int i = 0; i < AI + 3 && busy; i++) @(negedge clk);
    cmp("busy_done", 8'h00, 8'(busy));
  endtask
  task automatic hw_reset();
    arst_n = 1'b0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    defaults_idle();
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    void'($urandom(1274));
    {arst_n, ap_done, temp_flag, selftest, refresh} = '0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    rd_chk(8'h00, info(1'b1, 2'h0));
    defaults_idle();
    u_ctl.wr(8'h00, 8'hFF);
    u_ctl.wr(8'h20, 8'h00);
    rd_chk(8'h00, info(1'b0, 2'h0));
    rd_chk(8'h20, PAT_A);
    rd_chk(8'h28, PAT_B);
    rd_chk(8'h05, MAKER);
    {temp_flag, refresh} = 4'($urandom);
    rd_chk(8'h04, {temp_flag, 4'h0, refresh});
    foreach (wo_list[i]) rd_chk(wo_list[i], 8'h00);
    for (int b = 2; b <= 4; b++) begin
      for (int w = 1; w <= 6; w++) begin
        op = {3'(w), b == 2 ? 1'($urandom) : 1'b0, 1'($urandom), 3'(b)};
        u_ctl.wr(8'h01, op);
        cmp("burst_length", 8'(b), 8'(blen));
        cmp("burst_order", 8'(op[3]), 8'(bord));
        cmp("burst_wrap", 8'(op[4]), 8'(bwrap));
        cmp("recovery", 8'(w + 2), 8'(wrc));
        ap_done = 1'b1;
        for (int k = 1; k <= 10; k++) begin
          @(negedge clk);
          ap_done = 1'b0;
          cmp("precharge", 8'(k == w + 2), 8'(pre));
        end
      end
    end
    op = 8'($urandom);
    u_ctl.wr(8'h02, {4'h0, op[3:0]});
    u_ctl.wr(8'h03, {4'h0, op[7:4]});
    u_ctl.wr(8'h09, op);
    u_ctl.wr(8'h10, ~op);
    cmp("latency", {4'h0, op[3:0]}, lat);
    cmp("drive", 8'(op[7:4]), 8'(drv));
    cmp("test_ctl", op, tctl);
    cmp("partial_array_refresh", ~op, partial_array_refresh);
    u_ctl.wr(8'h3F, 8'h00);
    defaults_idle();
    for (int p = 3; p >= 1; p--) begin
      hw_reset();
      selftest = 2'(p);
      // any operand but the init code must leave the self-test field alone
      u_ctl.wr(8'h0A, 8'h00);
      repeat (CC + 2) @(negedge clk);
      rd_chk(8'h00, info(1'b0, 2'h0));
      u_ctl.wr(8'h0A, 8'hFF);
      repeat (CC + 2) @(negedge clk);
      rd_chk(8'h00, info(1'b0, 2'(p)));
      cmp("factory", 8'(p != 3), 8'(fact));
      selftest = 2'h3;
      u_ctl.wr(8'h0A, 8'hFF);
      repeat (CC + 2) @(negedge clk);
      rd_chk(8'h00, info(1'b0, 2'(p)));
    end
    results();
  end
endmodule
